/* File: hw/pier_top.sv */
`timescale 1ns/1ps
module pier_top #(
  parameter bit REDUCED_PIN = 1'b0
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // register bus, APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // peripheral event pulses, same clock
  input  wire logic [7:0]  i_evt1,
  input  wire logic [7:0]  i_evt2,
  input  wire logic [7:0]  i_evt3,
  // third priority group, held outside this block
  input  wire logic [7:0]  i_pr3,
  // requests toward the core
  output logic             o_irq_high,
  output logic             o_irq_low,
  output logic             o_irq_periph,
  output logic             o_prio_scheme_en
);
  import pier_pkg::*;

  localparam logic [7:0] M1 = pier_mask(2'd0, REDUCED_PIN);
  localparam logic [7:0] M2 = pier_mask(2'd1, REDUCED_PIN);
  localparam logic [7:0] M3 = pier_mask(2'd2, REDUCED_PIN);

  typedef struct packed {
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic [7:0]  en3;
    logic [7:0]  pr1;
    logic [7:0]  pr2;
    logic        prio_en;
    logic        pge;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    logic        irq_high;
    logic        irq_low;
    logic        irq_periph;
    logic        touched;
  } pier_top_s;

  // reset image; unimplemented bits come up clear
  localparam pier_top_s RST_TOP = '{
    en1:        RST_EN1 & M1,
    en2:        RST_EN2 & M2,
    en3:        RST_EN3 & M3,
    pr1:        RST_PR1 & M1,
    pr2:        RST_PR2 & M2,
    prio_en:    1'b0,
    pge:        1'b0,
    ready:      1'b0,
    slverr:     1'b0,
    rdata:      32'h0000_0000,
    irq_high:   1'b0,
    irq_low:    1'b0,
    irq_periph: 1'b0,
    touched:    1'b0
  };

  pier_top_s  q;
  pier_top_s  d;

  logic       setup;
  logic       wr_fire;
  logic       mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] clr3;
  logic [7:0] flag1;
  logic [7:0] flag2;
  logic [7:0] flag3;
  logic       req_high;
  logic       req_low;
  logic       req_periph;

  // bus phase decode; the answer always comes one cycle after setup
  assign setup   = i_psel & ~i_penable;
  assign wbyte   = i_pwdata[7:0];
  assign wr_fire = i_psel & i_penable & q.ready & i_pwrite &
                   i_pstrb[0] & mapped;

  // address decode and read mux, narrow data in the low byte
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (i_paddr)
      OFS_EN1:  rd_byte = q.en1;                      // R3
      OFS_EN2:  rd_byte = q.en2;                      // R4
      OFS_EN3:  rd_byte = q.en3;                      // R5
      OFS_PR1:  rd_byte = q.pr1;                      // R6
      OFS_PR2:  rd_byte = q.pr2;                      // R7
      OFS_CTRL: begin
        rd_byte[CTRL_PRIO_BIT] = q.prio_en;           // R10
        rd_byte[CTRL_PGE_BIT]  = q.pge;
      end
      OFS_FLG1: rd_byte = flag1;
      OFS_FLG2: rd_byte = flag2;
      OFS_FLG3: rd_byte = flag3;
      OFS_STAT: begin
        rd_byte[STAT_HIGH_BIT] = q.irq_high;
        rd_byte[STAT_LOW_BIT]  = q.irq_low;
        rd_byte[STAT_PER_BIT]  = q.irq_periph;
      end
      default:  mapped = 1'b0;
    endcase
  end

  // write-one-to-clear pulses for the flag groups
  always_comb begin
    clr1 = 8'h00;
    clr2 = 8'h00;
    clr3 = 8'h00;
    if (wr_fire && i_paddr == OFS_FLG1) clr1 = wbyte;
    if (wr_fire && i_paddr == OFS_FLG2) clr2 = wbyte;
    if (wr_fire && i_paddr == OFS_FLG3) clr3 = wbyte;
  end

  // next state: bus answer, register writes, request outputs
  always_comb begin
    d       = q;
    d.ready = setup;
    if (setup) begin
      // read data caught at setup, so it reflects that cycle
      d.rdata  = {24'h00_0000, rd_byte};
      d.slverr = ~mapped;
    end
    if (wr_fire) begin
      d.touched = 1'b1;
      case (i_paddr)
        OFS_EN1:  d.en1 = wbyte & M1;                 // R3 R8
        OFS_EN2:  d.en2 = wbyte & M2;                 // R4 R8
        OFS_EN3:  d.en3 = wbyte & M3;                 // R5
        OFS_PR1:  d.pr1 = wbyte & M1;                 // R6 R8
        OFS_PR2:  d.pr2 = wbyte & M2;                 // R7 R8
        OFS_CTRL: begin
          d.prio_en = wbyte[CTRL_PRIO_BIT];           // R10
          d.pge     = wbyte[CTRL_PGE_BIT];
        end
        default:  ;
      endcase
    end
    // one cycle of latency, trades speed for glitch-free outputs
    d.irq_high   = req_high;                          // R2
    d.irq_low    = req_low;                           // R2
    d.irq_periph = req_periph;                        // R1
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= RST_TOP;
    end else begin
      q <= d;
    end
  end

  // flag store
  pier_flags #(
    .REDUCED_PIN (REDUCED_PIN)
  ) u_flags (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_evt1  (i_evt1),
    .i_evt2  (i_evt2),
    .i_evt3  (i_evt3),
    .i_clr1  (clr1),
    .i_clr2  (clr2),
    .i_clr3  (clr3),
    .o_flag1 (flag1),
    .o_flag2 (flag2),
    .o_flag3 (flag3)
  );

  // level routing
  pier_route u_route (
    .i_flag1      (flag1),
    .i_flag2      (flag2),
    .i_flag3      (flag3),
    .i_en1        (q.en1),
    .i_en2        (q.en2),
    .i_en3        (q.en3),
    .i_pr1        (q.pr1),
    .i_pr2        (q.pr2),
    .i_pr3        (i_pr3),
    .i_prio_en    (q.prio_en),
    .i_pge        (q.pge),
    .o_req_high   (req_high),
    .o_req_low    (req_low),
    .o_req_periph (req_periph)
  );

  // outputs straight from the state register
  assign o_prdata         = q.rdata;
  assign o_pready         = q.ready;
  assign o_pslverr        = q.slverr;
  assign o_irq_high       = q.irq_high;
  assign o_irq_low        = q.irq_low;
  assign o_irq_periph     = q.irq_periph;
  assign o_prio_scheme_en = q.prio_en;

  // checks on the register bank and routing
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_wr(logic [7:0] a);
    i_psel && !i_penable && i_pwrite && i_pstrb[0] && i_paddr == a
    ##1 i_psel && i_penable && o_pready;
  endsequence

  sequence s_rd(logic [7:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a
    ##1 i_psel && i_penable;
  endsequence

  a_bus_answer: assert property (
    setup |=> o_pready ##1 !o_pready)
    else $error("bus answer not exactly one cycle");

  a_single_gate: assert property ( // R1
    !q.prio_en && !q.pge |=> !o_irq_periph)
    else $error("single level request without global enable");

  a_prio_off_split: assert property ( // R2
    !q.prio_en |=> !o_irq_high && !o_irq_low)
    else $error("level request while priorities off");

  a_en1_reset: assert property ( // R3
    !q.touched |-> q.en1 == 8'h00 && q.en2 == 8'h00)
    else $error("enable 1 or 2 not clear after reset");

  a_en2_unimpl: assert property ( // R4
    s_rd(OFS_EN2) |-> o_pready && !o_prdata[7] && !o_prdata[5])
    else $error("enable 2 reserved bit read as one");

  a_en3_reset: assert property ( // R5
    !q.touched |-> q.en3 == M3 && q.pr1 == M1)
    else $error("enable 3 or priority 1 not set after reset");

  a_pr1_write: assert property ( // R6
    s_wr(OFS_PR1) |=> q.pr1 == ($past(i_pwdata[7:0]) & M1))
    else $error("priority 1 write not stored");

  a_pr2_reset: assert property ( // R7
    !q.touched |-> q.pr2 == (RST_PR2 & M2) && !q.pr2[4])
    else $error("priority 2 reset image wrong");

  a_pr2_unimpl: assert property ( // R7
    s_rd(OFS_PR2) |-> !o_prdata[7] && !o_prdata[5])
    else $error("priority 2 reserved bit read as one");

  a_variant_zero: assert property ( // R8
    ((q.en1 | q.pr1) & ~M1) == 8'h00 &&
    ((q.en2 | q.pr2) & ~M2) == 8'h00 &&
    ((flag1 & ~M1) | (flag2 & ~M2)) == 8'h00)
    else $error("unimplemented bit held a one");

  a_flag_set: assert property ( // R9
    (i_evt1 & M1) != 8'h00 |=> (flag1 & $past(i_evt1) & M1)
                              == ($past(i_evt1) & M1))
    else $error("event did not set its flag");

  a_ctrl_write: assert property ( // R10
    s_wr(OFS_CTRL) |=> o_prio_scheme_en == $past(i_pwdata[7]))
    else $error("priority scheme bit not written");

  a_high_route: assert property ( // R11
    q.prio_en && pier_any(flag1, q.en1, q.pr1) |=> o_irq_high)
    else $error("high source did not raise high request");

  a_low_route: assert property ( // R11
    q.prio_en && pier_any(flag2, q.en2, ~q.pr2) |=> o_irq_low)
    else $error("low source did not raise low request");

  a_unmapped_err: assert property (
    setup && !mapped |=> o_pready && o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");

  a_en1_write: assert property ( // R3
    s_wr(OFS_EN1) |=> q.en1 == ($past(i_pwdata[7:0]) & M1))
    else $error("enable 1 write not stored");

  a_en2_write: assert property ( // R4
    s_wr(OFS_EN2) |=> q.en2 == ($past(i_pwdata[7:0]) & M2))
    else $error("enable 2 write not stored");

  a_en3_write: assert property ( // R5
    s_wr(OFS_EN3) |=> q.en3 == ($past(i_pwdata[7:0]) & M3))
    else $error("enable 3 write not stored");

  a_pr2_write: assert property ( // R7
    s_wr(OFS_PR2) |=> q.pr2 == ($past(i_pwdata[7:0]) & M2))
    else $error("priority 2 write not stored");

  a_en1_variant: assert property ( // R8
    s_rd(OFS_EN1) |-> (o_prdata[7:0] & ~M1) == 8'h00)
    else $error("enable 1 absent source read as one");

  a_pr1_variant: assert property ( // R8
    s_rd(OFS_PR1) |-> (o_prdata[7:0] & ~M1) == 8'h00)
    else $error("priority 1 absent source read as one");

  a_flag_clear: assert property (
    wr_fire && i_paddr == OFS_FLG1 && i_evt1 == 8'h00
    |=> (flag1 & $past(i_pwdata[7:0])) == 8'h00)
    else $error("write one did not clear the flag");

  a_ctrl_read: assert property ( // R10
    s_rd(OFS_CTRL) |-> o_prdata[CTRL_PRIO_BIT] == o_prio_scheme_en)
    else $error("priority scheme bit read back wrong");

  a_rdata_wide: assert property (
    o_pready |-> o_prdata[31:8] == 24'h00_0000)
    else $error("read data above the low byte not zero");

  a_mapped_ok: assert property (
    setup && mapped |=> o_pready && !o_pslverr)
    else $error("mapped access refused");

  a_idle_quiet: assert property (
    !i_psel |=> !o_pready)
    else $error("bus answer without a request");

  a_prio_on_gate: assert property ( // R11
    q.prio_en |=> !o_irq_periph)
    else $error("single level request while priorities on");

  a_periph_route: assert property ( // R11
    !q.prio_en && q.pge && pier_any(flag1, q.en1, 8'hFF) |=> o_irq_periph)
    else $error("enabled source did not raise single request");

  a_level_quiet: assert property ( // R11
    q.prio_en && !pier_any(flag1, q.en1, q.pr1) &&
    !pier_any(flag2, q.en2, q.pr2) && !pier_any(flag3, q.en3, i_pr3)
    |=> !o_irq_high)
    else $error("high request with no high source pending");
endmodule

/* File: hw/pier_pkg.sv */
// Operation
// R1 - priorities off: no peripheral request passes without global enable
// R2 - priority bits steer the request level only while priorities are on
// R3 - enable register 1: eight read/write enables, cleared at reset
// R4 - enable register 2: six enables cleared at reset, bits 7 and 5 zero
// R5 - enable register 3: eight bus controller enables, set at reset
// R6 - priority register 1 mirrors enable 1, set at reset, one is high
// R7 - priority register 2 mirrors enable 2, bit 4 resets zero, others one
// R8 - reduced pin: slave port, comparator, enhanced capture bits read zero
// R9 - a flag sets on its event whatever the enable bits hold
// R10 - priority scheme enable sits at bit 7; one gives two levels
// R11 - requests are OR of flag AND enable, split by priority bit
package pier_pkg;

  // register byte offsets on the register bus
  localparam logic [7:0] OFS_EN1  = 8'h00;
  localparam logic [7:0] OFS_EN2  = 8'h04;
  localparam logic [7:0] OFS_EN3  = 8'h08;
  localparam logic [7:0] OFS_PR1  = 8'h0C;
  localparam logic [7:0] OFS_PR2  = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_FLG1 = 8'h18;
  localparam logic [7:0] OFS_FLG2 = 8'h1C;
  localparam logic [7:0] OFS_FLG3 = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;

  // reset values
  localparam logic [7:0] RST_EN1 = 8'h00;
  localparam logic [7:0] RST_EN2 = 8'h00;
  localparam logic [7:0] RST_EN3 = 8'hFF;
  localparam logic [7:0] RST_PR1 = 8'hFF;
  localparam logic [7:0] RST_PR2 = 8'h4F;
  localparam logic [7:0] RST_FLG = 8'h00;

  // implemented bits, full and reduced pin variants
  localparam logic [7:0] MSK_FULL1 = 8'hFF;
  localparam logic [7:0] MSK_FULL2 = 8'h5F;
  localparam logic [7:0] MSK_FULL3 = 8'hFF;
  localparam logic [7:0] MSK_RED1  = 8'h7F;
  localparam logic [7:0] MSK_RED2  = 8'h1E;

  // control and status field positions
  localparam int unsigned CTRL_PRIO_BIT = 7;
  localparam int unsigned CTRL_PGE_BIT  = 6;
  localparam int unsigned STAT_HIGH_BIT = 0;
  localparam int unsigned STAT_LOW_BIT  = 1;
  localparam int unsigned STAT_PER_BIT  = 2;

  // implemented-bit mask of a source group
  function automatic logic [7:0] pier_mask(input logic [1:0] grp,
                                           input logic       reduced);
    logic [7:0] m;
    m = MSK_FULL3;
    if (grp == 2'd0) m = reduced ? MSK_RED1 : MSK_FULL1;
    if (grp == 2'd1) m = reduced ? MSK_RED2 : MSK_FULL2;
    return m;
  endfunction

  // any source pending, enabled and of the wanted level
  function automatic logic pier_any(input logic [7:0] flg,
                                    input logic [7:0] ena,
                                    input logic [7:0] lvl);
    return |(flg & ena & lvl);
  endfunction

endpackage

/* File: hw/pier_flags.sv */
`timescale 1ns/1ps
module pier_flags #(
  parameter bit REDUCED_PIN = 1'b0
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_evt1,
  input  wire logic [7:0] i_evt2,
  input  wire logic [7:0] i_evt3,
  input  wire logic [7:0] i_clr1,
  input  wire logic [7:0] i_clr2,
  input  wire logic [7:0] i_clr3,
  output logic      [7:0] o_flag1,
  output logic      [7:0] o_flag2,
  output logic      [7:0] o_flag3
);
  import pier_pkg::*;

  localparam logic [7:0] M1 = pier_mask(2'd0, REDUCED_PIN);
  localparam logic [7:0] M2 = pier_mask(2'd1, REDUCED_PIN);
  localparam logic [7:0] M3 = pier_mask(2'd2, REDUCED_PIN);

  typedef struct packed {
    logic [7:0] f1;
    logic [7:0] f2;
    logic [7:0] f3;
  } pier_flags_s;

  pier_flags_s q;
  pier_flags_s d;

  // events set regardless of enables; a set beats a same-cycle clear
  always_comb begin
    d    = q;
    d.f1 = ((q.f1 & ~i_clr1) | i_evt1) & M1; // R9
    d.f2 = ((q.f2 & ~i_clr2) | i_evt2) & M2; // R9
    d.f3 = ((q.f3 & ~i_clr3) | i_evt3) & M3; // R9
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '{f1: RST_FLG, f2: RST_FLG, f3: RST_FLG};
    end else begin
      q <= d;
    end
  end

  assign o_flag1 = q.f1;
  assign o_flag2 = q.f2;
  assign o_flag3 = q.f3;
endmodule

/* File: hw/pier_route.sv */
`timescale 1ns/1ps
module pier_route (
  input  wire logic [7:0] i_flag1,
  input  wire logic [7:0] i_flag2,
  input  wire logic [7:0] i_flag3,
  input  wire logic [7:0] i_en1,
  input  wire logic [7:0] i_en2,
  input  wire logic [7:0] i_en3,
  input  wire logic [7:0] i_pr1,
  input  wire logic [7:0] i_pr2,
  input  wire logic [7:0] i_pr3,
  input  wire logic       i_prio_en,
  input  wire logic       i_pge,
  output logic            o_req_high,
  output logic            o_req_low,
  output logic            o_req_periph
);
  import pier_pkg::*;

  logic hi_any;
  logic lo_any;
  logic all_any;

  // per-level OR of flag AND enable, split by the priority bit
  always_comb begin
    hi_any  = pier_any(i_flag1, i_en1, i_pr1) |
              pier_any(i_flag2, i_en2, i_pr2) |
              pier_any(i_flag3, i_en3, i_pr3); // R11
    lo_any  = pier_any(i_flag1, i_en1, ~i_pr1) |
              pier_any(i_flag2, i_en2, ~i_pr2) |
              pier_any(i_flag3, i_en3, ~i_pr3); // R11
    all_any = hi_any | lo_any;
    // priority bits only matter with the scheme on
    o_req_high   = i_prio_en & hi_any; // R2
    o_req_low    = i_prio_en & lo_any; // R2
    // single level request needs the peripheral global enable
    o_req_periph = ~i_prio_en & i_pge & all_any; // R1
  end
endmodule

/* File: tb/pier_evt_src.sv */
`timescale 1ns/1ps
module pier_evt_src (
  input  wire logic       i_clk,
  input  wire logic       i_fire,
  input  wire logic [1:0] i_grp,
  input  wire logic [7:0] i_bits,
  output logic      [7:0] o_evt1,
  output logic      [7:0] o_evt2,
  output logic      [7:0] o_evt3
);
  // peripheral events last one cycle; a held level would re-set flags
  always_ff @(posedge i_clk) begin
    o_evt1 <= (i_fire && i_grp == 2'd0) ? i_bits : 8'h00;
    o_evt2 <= (i_fire && i_grp == 2'd1) ? i_bits : 8'h00;
    o_evt3 <= (i_fire && i_grp == 2'd2) ? i_bits : 8'h00;
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pier_pkg::*;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] rst_full;
    logic [7:0] rst_red;
    logic [7:0] wdata;
    logic [7:0] rd_full;
    logic [7:0] rd_red;
  } pier_row_s;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic [31:0] prdata_red;
  logic        pready;
  logic        pslverr;
  logic        fire;
  logic [1:0]  grp;
  logic [7:0]  bits;
  logic [7:0]  pr3;
  logic [7:0]  evt1;
  logic [7:0]  evt2;
  logic [7:0]  evt3;
  logic        irq_high;
  logic        irq_low;
  logic        irq_periph;
  logic        prio_en;
  logic [31:0] rd;
  logic [31:0] rd_red;
  logic        err;
  int          error_cnt;
  int          tests_run;
  // reset value and readback of each enable and priority register, full and reduced pin
  pier_row_s rows [5] = '{
    '{OFS_EN1, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h7F},
    '{OFS_EN2, 8'h00, 8'h00, 8'hFF, 8'h5F, 8'h1E},
    '{OFS_EN3, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00},
    '{OFS_PR1, 8'hFF, 8'h7F, 8'h00, 8'h00, 8'h00},
    '{OFS_PR2, 8'h4F, 8'h0E, 8'hFF, 8'h5F, 8'h1E}};

  pier_top #(.REDUCED_PIN(1'b0)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_evt1(evt1), .i_evt2(evt2), .i_evt3(evt3),
    .i_pr3(pr3), .o_irq_high(irq_high), .o_irq_low(irq_low),
    .o_irq_periph(irq_periph), .o_prio_scheme_en(prio_en));
  // reduced pin variant shares the bus; only its read data is judged
  pier_top #(.REDUCED_PIN(1'b1)) i_red (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata_red), .o_pready(),
    .o_pslverr(), .i_evt1(evt1), .i_evt2(evt2), .i_evt3(evt3),
    .i_pr3(pr3), .o_irq_high(), .o_irq_low(), .o_irq_periph(),
    .o_prio_scheme_en());
  pier_evt_src i_src (
    .i_clk(clk), .i_fire(fire), .i_grp(grp), .i_bits(bits),
    .o_evt1(evt1), .o_evt2(evt2), .o_evt3(evt3));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("tests %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; pready ends this wait, else the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    rd_red  = prdata_red;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle event pulse from the source model, then let it route
  task automatic pulse(input logic [1:0] g, input logic [7:0] b);
    @(posedge clk);
    fire <= 1'b1;
    grp  <= g;
    bits <= b;
    @(posedge clk);
    fire <= 1'b0;
    cyc(4);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // hang guard, far beyond the hundred or so cycles of the run
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hF;
    fire = 1'b0; grp = 2'd0; bits = 8'h00; pr3 = 8'h00;
    do_reset();
    cyc(1);
    chk("irq after reset", 32'h0,
        {28'h0, irq_high, irq_low, irq_periph, prio_en});
    // reset values, then write and readback of each enable and priority register
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 8'h00, 4'hF);
      chk("reset full", {24'h0, rows[i].rst_full}, rd);
      chk("reset reduced", {24'h0, rows[i].rst_red}, rd_red);
      apb(1'b1, rows[i].addr, rows[i].wdata, 4'hF);
      apb(1'b0, rows[i].addr, 8'h00, 4'hF);
      chk("readback full", {24'h0, rows[i].rd_full}, rd);
      chk("readback reduced", {24'h0, rows[i].rd_red}, rd_red);
      chk("mapped no error", 32'h0, {31'h0, err});
    end
    $display("register table done");
    // unmapped address and strobe-off write
    apb(1'b0, 8'h28, 8'h00, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, OFS_EN1, 8'h00, 4'h0);
    apb(1'b0, OFS_EN1, 8'h00, 4'hF);
    chk("strobe off", 32'hFF, rd);
    $display("bus refusals done");
    // single level: global enable gates the periph request
    apb(1'b1, OFS_CTRL, 8'h40, 4'hF);
    pulse(2'd0, 8'h01);
    chk("periph on", 32'h1, {31'h0, irq_periph});
    chk("levels off", 32'h0, {30'h0, irq_high, irq_low});
    apb(1'b1, OFS_CTRL, 8'h00, 4'hF);
    cyc(3);
    chk("periph gated", 32'h0, {31'h0, irq_periph});
    $display("single level done");
    // two levels: priority bit steers, global enable ignored
    apb(1'b1, OFS_CTRL, 8'h80, 4'hF);
    cyc(3);
    chk("scheme out", 32'h1, {31'h0, prio_en});
    chk("low level", 32'h2, {29'h0, irq_high, irq_low, irq_periph});
    apb(1'b1, OFS_PR1, 8'h01, 4'hF);
    cyc(3);
    chk("high level", 32'h4, {29'h0, irq_high, irq_low, irq_periph});
    apb(1'b0, OFS_STAT, 8'h00, 4'hF);
    chk("status", 32'h1, rd);
    $display("two levels done");
    // flag sets with its enable clear and raises no request
    apb(1'b1, OFS_FLG1, 8'h01, 4'hF);
    pr3 <= 8'hFF;
    pulse(2'd2, 8'h08);
    apb(1'b0, OFS_FLG3, 8'h00, 4'hF);
    chk("flag polled", 32'h08, rd);
    chk("no request", 32'h0, {30'h0, irq_high, irq_low});
    $display("polling done");
    // third group is steered by its outside priority bits
    apb(1'b1, OFS_EN3, 8'h08, 4'hF);
    cyc(3);
    chk("group3 high", 32'h4, {29'h0, irq_high, irq_low, irq_periph});
    @(posedge clk);
    pr3 <= 8'h00;
    cyc(3);
    chk("group3 low", 32'h2, {29'h0, irq_high, irq_low, irq_periph});
    $display("third group done");
    // second reset in mid-run restores defaults
    do_reset();
    apb(1'b0, OFS_EN1, 8'h00, 4'hF);
    chk("reset again", 32'h0, rd);
    chk("scheme cleared", 32'h0, {31'h0, prio_en});
    $display("second reset done");
    wrap_up();
  end
endmodule
